//--- swst_consts.svh
// timing constants for the single wire slot timing master
// Functional notes
// - every bit slot lasts at least 60 us and under 120 us
// - write one: low at least 1 us, under 15 us, then release
// - write zero: low at least 60 us, within the slot
// - at least 1 us released recovery between slots
// - read slot starts with 1 to 15 us low, then release
// - read bit valid 1 us after fall, held 14 us; sample inside 15 us
// - after reset, wait 480 us high before next reset or slot
// - total program pulse time per address never exceeds 5 ms
// - reset pulse low at least 480 us, then release and listen
// - program level held 480 us, then back to pulled-up idle
`ifndef SWST_CONSTS_SVH
`define SWST_CONSTS_SVH
`define SWST_CLK_MHZ 20
`define SWST_SLOT_US 70
`define SWST_ONE_LOW_US 6
`define SWST_ZERO_LOW_US 62
`define SWST_READ_LOW_US 2
`define SWST_SAMPLE_US 12
`define SWST_REC_US 2
`define SWST_RST_LOW_US 500
`define SWST_RST_HIGH_US 500
`define SWST_PRES_SAMPLE_US 70
`define SWST_PROG_US 480
`define SWST_PROG_MAX_US 5000
`define SWST_LOW_MIN_US 1
`define SWST_LOW_MAX_US 15
`define SWST_SLOT_MIN_US 60
`define SWST_SLOT_MAX_US 120
`define SWST_REC_MIN_US 1
`define SWST_RST_MIN_US 480
`define SWST_CYC(us) ((us) * `SWST_CLK_MHZ)
`endif

//--- swst_pkg.sv
// types for the single wire slot timing master
package swst_pkg;
    typedef enum logic [2:0] {
        SWST_CMD_RESET,
        SWST_CMD_WRITE0,
        SWST_CMD_WRITE1,
        SWST_CMD_READ,
        SWST_CMD_PROGRAM
    } swst_cmd_t;
    typedef enum logic [2:0] {
        SWST_IDLE,
        SWST_LOW,
        SWST_HIGH,
        SWST_PROG,
        SWST_REC
    } swst_state_t;
endpackage : swst_pkg

//--- swst_fifo.sv
// valid/ready fifo for command words
module swst_fifo #(
    parameter int WIDTH = 3,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
    logic pushEn;
    logic popEn;
    assign inReady = (wrPtr - rdPtr) != (AW+1)'(DEPTH);
    assign outValid = wrPtr != rdPtr;
    assign outData = mem[rdPtr[AW-1:0]];
    assign pushEn = inValid && inReady;
    assign popEn = outValid && outReady;
    always_ff @(posedge ref_clk) begin
        if (pushEn) begin
            mem[wrPtr[AW-1:0]] <= inData;
        end
    end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            if (pushEn) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (popEn) begin
                rdPtr <= rdPtr + 1'b1;
            end
        end
    end
endmodule : swst_fifo

//--- swst_master.sv
// single wire slot timing master: reset, write, read and program slots
`include "swst_consts.svh"
module swst_master #(
    parameter int PROG_MAX_CYC = `SWST_CYC(`SWST_PROG_MAX_US),
    parameter int RST_CYC = `SWST_CYC(`SWST_RST_LOW_US),
    parameter int PROG_CYC = `SWST_CYC(`SWST_PROG_US)
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic [2:0] cmdCode,
    input wire logic progClear,
    output logic resultValid,
    output logic resultBit,
    output logic busy,
    output logic progLimit,
    input wire logic lineIn,
    output logic lineOut,
    output logic lineOe,
    output logic progOe
);
    // ------------------------------------------------------------
    // timing counts
    // ------------------------------------------------------------
    localparam int SLOT_CYC = `SWST_CYC(`SWST_SLOT_US);
    localparam int ONE_CYC = `SWST_CYC(`SWST_ONE_LOW_US);
    localparam int ZERO_CYC = `SWST_CYC(`SWST_ZERO_LOW_US);
    localparam int READ_CYC = `SWST_CYC(`SWST_READ_LOW_US);
    localparam int SAMP_CYC = `SWST_CYC(`SWST_SAMPLE_US);
    localparam int REC_CYC = `SWST_CYC(`SWST_REC_US);
    localparam int RSTH_CYC = `SWST_CYC(`SWST_RST_HIGH_US);
    localparam int PRES_CYC = `SWST_CYC(`SWST_PRES_SAMPLE_US);
    localparam int LOW_MIN_CYC = `SWST_CYC(`SWST_LOW_MIN_US);
    localparam int LOW_MAX_CYC = `SWST_CYC(`SWST_LOW_MAX_US);
    localparam int SLOT_MIN_CYC = `SWST_CYC(`SWST_SLOT_MIN_US);
    localparam int SLOT_MAX_CYC = `SWST_CYC(`SWST_SLOT_MAX_US);
    localparam int REC_MIN_CYC = `SWST_CYC(`SWST_REC_MIN_US);
    localparam int RST_MIN_CYC = `SWST_CYC(`SWST_RST_MIN_US);
    localparam int CW = 20;
    // ------------------------------------------------------------
    // command fifo
    // ------------------------------------------------------------
    logic qValid;
    logic qReady;
    logic [2:0] qData;
    swst_fifo #(.WIDTH(3), .DEPTH(16)) u_fifo (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .inValid(cmdValid),
        .inReady(cmdReady),
        .inData(cmdCode),
        .outValid(qValid),
        .outReady(qReady),
        .outData(qData)
    );
    swst_pkg::swst_state_t state;
    swst_pkg::swst_cmd_t cmd;
    logic [CW-1:0] cnt;
    logic [CW-1:0] lowLen;
    logic [CW-1:0] highLen;
    logic [CW-1:0] progTotal;
    logic sampled;
    logic takeProg;
    logic takeLow;
    logic [CW-1:0] lowRun;
    logic [CW-1:0] highRun;
    logic [CW-1:0] slotRun;
    logic afterRst;
    assign qReady = (state == swst_pkg::SWST_IDLE) && !progLimit;
    assign takeProg = qValid && qReady && swst_pkg::swst_cmd_t'(qData) == swst_pkg::SWST_CMD_PROGRAM;
    assign takeLow = qValid && qReady && !takeProg;
    assign busy = state != swst_pkg::SWST_IDLE;
    // ------------------------------------------------------------
    // slot sequencer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state <= swst_pkg::SWST_IDLE;
            cmd <= swst_pkg::SWST_CMD_RESET;
            cnt <= '0;
            lowLen <= '0;
            highLen <= '0;
        end else begin
            case (state)
                swst_pkg::SWST_IDLE: begin
                    cnt <= '0;
                    if (qValid && qReady) begin
                        cmd <= swst_pkg::swst_cmd_t'(qData);
                        case (swst_pkg::swst_cmd_t'(qData))
                            swst_pkg::SWST_CMD_RESET: begin
                                lowLen <= CW'(RST_CYC);
                                highLen <= CW'(RSTH_CYC);
                            end
                            swst_pkg::SWST_CMD_WRITE0: begin
                                lowLen <= CW'(ZERO_CYC);
                                highLen <= CW'(SLOT_CYC - ZERO_CYC);
                            end
                            swst_pkg::SWST_CMD_WRITE1: begin
                                lowLen <= CW'(ONE_CYC);
                                highLen <= CW'(SLOT_CYC - ONE_CYC);
                            end
                            default: begin
                                lowLen <= CW'(READ_CYC);
                                highLen <= CW'(SLOT_CYC - READ_CYC);
                            end
                        endcase
                        if (swst_pkg::swst_cmd_t'(qData) == swst_pkg::SWST_CMD_PROGRAM) begin
                            state <= swst_pkg::SWST_PROG;
                        end else begin
                            state <= swst_pkg::SWST_LOW;
                        end
                    end
                end
                swst_pkg::SWST_LOW: begin
                    if (cnt == lowLen - 1'b1) begin
                        cnt <= '0;
                        state <= swst_pkg::SWST_HIGH;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                swst_pkg::SWST_HIGH: begin
                    if (cnt == highLen - 1'b1) begin
                        cnt <= '0;
                        state <= swst_pkg::SWST_REC;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                swst_pkg::SWST_PROG: begin
                    if (cnt == CW'(PROG_CYC - 1)) begin
                        cnt <= '0;
                        state <= swst_pkg::SWST_REC;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                swst_pkg::SWST_REC: begin
                    if (cnt == CW'(REC_CYC - 1)) begin
                        cnt <= '0;
                        state <= swst_pkg::SWST_IDLE;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                default: state <= swst_pkg::SWST_IDLE;
            endcase
        end
    end
    // ------------------------------------------------------------
    // line drive: open drain low, separate program enable
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            lineOe <= 1'b0;
            progOe <= 1'b0;
        end else begin
            // drive starts on the accepting edge, so each pulse lasts exactly its count
            lineOe <= takeLow || ((state == swst_pkg::SWST_LOW) && !(cnt == lowLen - 1'b1));
            progOe <= takeProg || ((state == swst_pkg::SWST_PROG) && !(cnt == CW'(PROG_CYC - 1)));
        end
    end
    assign lineOut = 1'b0;
    // ------------------------------------------------------------
    // sampling: read bit inside 15 us window, presence after reset
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            resultValid <= 1'b0;
            resultBit <= 1'b0;
            sampled <= 1'b0;
        end else begin
            resultValid <= 1'b0;
            if (state == swst_pkg::SWST_IDLE) begin
                sampled <= 1'b0;
            end else if (state == swst_pkg::SWST_HIGH && !sampled) begin
                if (cmd == swst_pkg::SWST_CMD_READ && cnt == CW'(SAMP_CYC - READ_CYC)) begin
                    resultBit <= lineIn;
                    resultValid <= 1'b1;
                    sampled <= 1'b1;
                end else if (cmd == swst_pkg::SWST_CMD_RESET && cnt == CW'(PRES_CYC)) begin
                    resultBit <= !lineIn;
                    resultValid <= 1'b1;
                    sampled <= 1'b1;
                end
            end
        end
    end
    // ------------------------------------------------------------
    // program pulse budget; software clears on address change
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            progTotal <= '0;
        end else if (progClear) begin
            // a pulse cycle that meets the clear still counts against the budget
            progTotal <= CW'(state == swst_pkg::SWST_PROG);
        end else if (state == swst_pkg::SWST_PROG) begin
            progTotal <= progTotal + 1'b1;
        end
    end
    // refuse every new command unless a whole program pulse still fits in the budget
    assign progLimit = (progTotal + CW'(PROG_CYC)) > CW'(PROG_MAX_CYC);
    // ------------------------------------------------------------
    // check helpers
    // ------------------------------------------------------------
    // highRun starts saturated: a freshly reset line counts as long idle
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            lowRun <= '0;
            highRun <= '1;
            slotRun <= '0;
            afterRst <= 1'b0;
        end else begin
            lowRun <= lineOe ? lowRun + 1'b1 : '0;
            if (lineOe) begin
                highRun <= '0;
                afterRst <= cmd == swst_pkg::SWST_CMD_RESET;
            end else if (highRun != '1) begin
                highRun <= highRun + 1'b1;
            end
            slotRun <= busy ? slotRun + 1'b1 : '0;
        end
    end
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_rec;
        @(posedge ref_clk) disable iff (!resetn)
        $rose(lineOe) |-> highRun >= CW'(REC_MIN_CYC);
    endproperty
    a_rec: assert property (p_rec) else $error("recovery too short");
    property p_one;
        @(posedge ref_clk) disable iff (!resetn)
        $fell(lineOe) && cmd == swst_pkg::SWST_CMD_WRITE1
            |-> lowRun >= CW'(LOW_MIN_CYC) && lowRun < CW'(LOW_MAX_CYC);
    endproperty
    a_one: assert property (p_one) else $error("write one low wrong");
    property p_zero;
        @(posedge ref_clk) disable iff (!resetn)
        $fell(lineOe) && cmd == swst_pkg::SWST_CMD_WRITE0
            |-> lowRun >= CW'(SLOT_MIN_CYC) && lowRun < CW'(SLOT_MAX_CYC);
    endproperty
    a_zero: assert property (p_zero) else $error("write zero low wrong");
    property p_read;
        @(posedge ref_clk) disable iff (!resetn)
        $fell(lineOe) && cmd == swst_pkg::SWST_CMD_READ
            |-> lowRun >= CW'(LOW_MIN_CYC) && lowRun < CW'(LOW_MAX_CYC);
    endproperty
    a_read: assert property (p_read) else $error("read low wrong");
    property p_samp;
        @(posedge ref_clk) disable iff (!resetn)
        $rose(lineOe) && cmd == swst_pkg::SWST_CMD_READ |-> ##[200:299] resultValid;
    endproperty
    a_samp: assert property (p_samp) else $error("read sample outside window");
    property p_slot;
        @(posedge ref_clk) disable iff (!resetn)
        $rose(state == swst_pkg::SWST_REC) && cmd != swst_pkg::SWST_CMD_RESET
            && cmd != swst_pkg::SWST_CMD_PROGRAM
            |-> slotRun >= CW'(SLOT_MIN_CYC) && slotRun < CW'(SLOT_MAX_CYC);
    endproperty
    a_slot: assert property (p_slot) else $error("slot length wrong");
    property p_rst;
        @(posedge ref_clk) disable iff (!resetn)
        $fell(lineOe) && cmd == swst_pkg::SWST_CMD_RESET |-> lowRun >= CW'(RST_CYC);
    endproperty
    a_rst: assert property (p_rst) else $error("reset low too short");
    property p_prog;
        @(posedge ref_clk) disable iff (!resetn)
        progOe |-> progTotal < CW'(PROG_MAX_CYC);
    endproperty
    a_prog: assert property (p_prog) else $error("program over budget");
    property p_rsth;
        @(posedge ref_clk) disable iff (!resetn)
        $rose(lineOe) && afterRst |-> highRun >= CW'(RST_MIN_CYC);
    endproperty
    a_rsth: assert property (p_rsth) else $error("reset high too short");
    c_read: cover property (@(posedge ref_clk) resultValid && cmd == swst_pkg::SWST_CMD_READ);
    c_pres: cover property (@(posedge ref_clk) resultValid && cmd == swst_pkg::SWST_CMD_RESET);
    c_prog: cover property (@(posedge ref_clk) $fell(progOe));
    c_full: cover property (@(posedge ref_clk) !cmdReady);
endmodule : swst_master

//--- swst_slave_model.sv
// behavioural slave device hanging on the single wire line
module swst_slave_model (
    input wire logic line,
    input wire logic present,
    input wire logic readBit,
    output logic slaveOe,
    output logic lastWrite
);
    timeunit 1ns;
    timeprecision 1ns;
    realtime fallT;
    bit armed;
    initial begin
        slaveOe = 1'b0;
        lastWrite = 1'b0;
        armed = 1'b0;
    end
    // -----------------------------------------------------------------
    // slot timing: each master fall starts the internal delay, only while present is high
    // -----------------------------------------------------------------
    // own pulls are ignored, so a presence pulse is never taken for a slot
    always @(negedge line) begin
        if (present && !slaveOe) begin
            fallT = $realtime;
            armed = 1'b1;
            fork
                begin
                    #30000 lastWrite = line;
                end
                if (!readBit) begin
                    slaveOe = 1'b1;
                    #30000 slaveOe = 1'b0;
                end
            join_none
        end
    end
    // -----------------------------------------------------------------
    // reset detection and presence answer
    // -----------------------------------------------------------------
    // while present is high, any low longer than the longest slot counts as a reset
    always @(posedge line) begin
        if (armed && ($realtime - fallT > 120000)) begin
            armed = 1'b0;
            #30000 slaveOe = 1'b1;
            #100000 slaveOe = 1'b0;
        end
        armed = 1'b0;
    end
endmodule : swst_slave_model

//--- single_wire_slot_timing_tb_top.sv
// self-checking bench for the single wire slot timing master
`define SWST_CHK(a, b) begin nChecks++; if ((a) !== (b)) begin errCount++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module single_wire_slot_timing_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int RST = 4000;
    localparam int PROG = 100;
    localparam int PMAX = 500;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic cmdValid = 1'b0;
    logic [2:0] cmdCode = 3'h0;
    logic progClear = 1'b0;
    logic present = 1'b1;
    logic readBit = 1'b1;
    logic cmdReady, resultValid, resultBit, busy, progLimit, lineOut, lineOe, progOe;
    logic slaveOe, lastWrite;
    wire logic line;
    int errCount = 0, nChecks = 0;
    int pullCnt = 0, relCnt = 0, lastPull = 0, lastRel = 0, slotCnt = 0, lastSlot = 0;
    int progCnt = 0, lastProg = 0, progTotal = 0;
    always #25 ref_clk = ~ref_clk;
    // open drain: released line is pulled up, the program level also reads high
    assign line = !(lineOe || slaveOe);
    swst_master #(.PROG_MAX_CYC(PMAX), .RST_CYC(RST), .PROG_CYC(PROG)) dut (
        .ref_clk(ref_clk), .resetn(resetn), .cmdValid(cmdValid), .cmdReady(cmdReady),
        .cmdCode(cmdCode), .progClear(progClear), .resultValid(resultValid),
        .resultBit(resultBit), .busy(busy), .progLimit(progLimit), .lineIn(line),
        .lineOut(lineOut), .lineOe(lineOe), .progOe(progOe));
    swst_slave_model slave (.line(line), .present(present), .readBit(readBit),
        .slaveOe(slaveOe), .lastWrite(lastWrite));
    // -----------------------------------------------------------------
    // wire monitor: pull, release and slot lengths in cycles
    // -----------------------------------------------------------------
    // lengths are captured before their counters restart
    always @(posedge ref_clk) begin
        if (lineOe && pullCnt == 0) begin
            lastRel = relCnt;
            lastSlot = slotCnt;
            slotCnt = 0;
        end
        if (!lineOe && relCnt == 0) lastPull = pullCnt;
        pullCnt = lineOe ? pullCnt + 1 : 0;
        relCnt = lineOe ? 0 : relCnt + 1;
        slotCnt = slotCnt + 1;
        progCnt = progOe ? progCnt + 1 : 0;
        if (progOe) progTotal++;
        if (progClear) progTotal = 0;
        if (progOe) lastProg = progCnt;
    end
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : giveVerdict
    task automatic hang();
        errCount++;
        giveVerdict();
    endtask : hang
    task automatic send(input logic [2:0] code);
        int i;
        @(negedge ref_clk);
        cmdValid = 1'b1;
        cmdCode = code;
        for (i = 0; i < 20000; i++) begin
            @(posedge ref_clk);
            if (cmdReady) break;
        end
        if (i == 20000) hang();
        @(negedge ref_clk);
        cmdValid = 1'b0;
    endtask : send
    // idle means a few quiet cycles in a row, so queued commands are not missed
    task automatic waitIdle();
        int i, q;
        q = 0;
        for (i = 0; i < 50000 && q < 4; i++) begin
            @(posedge ref_clk);
            q = busy ? 0 : q + 1;
        end
        if (q < 4) hang();
    endtask : waitIdle
    task automatic waitResult();
        int i;
        for (i = 0; i < 30000; i++) begin
            @(posedge ref_clk);
            if (resultValid) break;
        end
        if (i == 30000) hang();
    endtask : waitResult
    task automatic tReset(input logic pres);
        present = pres;
        send(3'h0);
        waitResult();
        `SWST_CHK(resultBit, pres)
        `SWST_CHK(lastPull >= RST, 1'b1)
        send(3'h2);
        waitIdle();
        `SWST_CHK(lastRel >= 9600, 1'b1)
        $display("reset test done");
    endtask : tReset
    task automatic tWrite(input logic b);
        send(b ? 3'h2 : 3'h1);
        waitIdle();
        `SWST_CHK(lastWrite, b)
        if (b) `SWST_CHK(lastPull >= 20 && lastPull < 300, 1'b1)
        else `SWST_CHK(lastPull >= 1200 && lastPull < 2400, 1'b1)
        $display("write test done");
    endtask : tWrite
    task automatic tBackToBack();
        send(3'h1);
        send(3'h2);
        send(3'h1);
        waitIdle();
        `SWST_CHK(lastSlot >= 1220 && lastSlot < 2440, 1'b1)
        `SWST_CHK(lastRel >= 20, 1'b1)
        `SWST_CHK(lastWrite, 1'b0)
        $display("back to back test done");
    endtask : tBackToBack
    task automatic tRead(input logic b);
        readBit = b;
        send(3'h3);
        waitResult();
        `SWST_CHK(resultBit, b)
        waitIdle();
        `SWST_CHK(lastPull >= 20 && lastPull < 300, 1'b1)
        readBit = 1'b1;
        $display("read test done");
    endtask : tRead
    task automatic tProg();
        int k;
        @(negedge ref_clk);
        progClear = 1'b1;
        @(negedge ref_clk);
        progClear = 1'b0;
        for (k = 0; k < 5; k++) begin
            send(3'h4);
            waitIdle();
            `SWST_CHK(lastProg, PROG)
        end
        `SWST_CHK(progLimit, 1'b1)
        send(3'h4);
        repeat (300) @(posedge ref_clk);
        `SWST_CHK(progTotal <= PMAX, 1'b1)
        @(negedge ref_clk);
        progClear = 1'b1;
        @(negedge ref_clk);
        progClear = 1'b0;
        waitIdle();
        `SWST_CHK(progTotal, PROG)
        `SWST_CHK(progLimit, 1'b0)
        $display("program test done");
    endtask : tProg
    task automatic tFifo();
        int i;
        send(3'h0);
        for (i = 0; i < 20; i++) begin
            @(negedge ref_clk);
            if (!cmdReady) break;
            cmdValid = 1'b1;
            cmdCode = 3'h2;
            @(posedge ref_clk);
        end
        @(negedge ref_clk);
        cmdValid = 1'b0;
        `SWST_CHK(i >= 16 && i <= 17, 1'b1)
        waitIdle();
        `SWST_CHK(cmdReady, 1'b1)
        $display("fifo test done");
    endtask : tFifo
    initial begin
        repeat (2) @(negedge ref_clk);
        resetn = 1'b1;
        tReset(1'b1);
        tWrite(1'b1);
        tWrite(1'b0);
        tBackToBack();
        tRead(1'b0);
        tRead(1'b1);
        tProg();
        tReset(1'b0);
        tFifo();
        giveVerdict();
    end
    initial begin
        repeat (100000) @(posedge ref_clk);
        hang();
    end
endmodule : single_wire_slot_timing_tb_top
